// ### verilog/pwr_tmr_ctl_pkg.sv
package pwr_tmr_ctl_pkg;

	// ****************************************************************
	// Register addresses
	// ****************************************************************
	localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h87;
	localparam logic [7:0] TIMER_INT_CONTROL_ADDR = 8'h88;
	localparam logic [7:0] READ_UNMAPPED          = 8'h00;

	// ****************************************************************
	// Field layouts
	// ****************************************************************
	typedef struct packed {
		logic baud_double;
		logic frame_err_view_sel;
		logic reserved;
		logic cold_start_flag;
		logic general_flag_b;
		logic general_flag_a;
		logic deep_sleep_req;
		logic light_sleep_req;
	} power_control_type;

	typedef struct packed {
		logic timer_b_overflow;
		logic timer_b_run;
		logic timer_a_overflow;
		logic timer_a_run;
		logic ext_irq_b_flag;
		logic ext_irq_b_type;
		logic ext_irq_a_flag;
		logic ext_irq_a_type;
	} timer_int_control_type;

	// Cold-start flag is handled apart from this value
	localparam power_control_type POWER_CONTROL_RESET = '0;
	localparam timer_int_control_type TIMER_INT_CONTROL_RESET = '0;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic TRIGGER_LOW_LEVEL    = 1'b0;
	localparam logic TRIGGER_FALLING_EDGE = 1'b1;
	localparam logic VIEW_MODE_SELECT     = 1'b0;
	localparam logic VIEW_FRAME_ERROR     = 1'b1;
	localparam logic PIN_IDLE_LEVEL       = 1'b1;
	localparam logic COLD_START_SET       = 1'b1;

	localparam logic [1:0] SERIAL_MODE_1 = 2'h1;
	localparam logic [1:0] SERIAL_MODE_2 = 2'h2;
	localparam logic [1:0] SERIAL_MODE_3 = 2'h3;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_LIGHT_SLEEP,
		ST_DEEP_SLEEP
	} sleep_state_type;

endpackage

// ### verilog/power_timer_int_control_regs.sv
`timescale 1ns/1ps

// Function
// RQ1 - Baud-double doubles serial rate in mode 2, or modes 1/3 on timer-b.
// RQ2 - View selector steers serial control bit 7 to mode bit or frame error.
// RQ3 - Cold-start flag set by power-on reset, kept through other resets.
// RQ4 - Software should clear cold-start flag after reading it.
// RQ5 - Two general flags are plain read/write storage, no side effects.
// RQ6 - Deep sleep stops core and peripheral clocks, holds program counter.
// RQ7 - Wake from deep sleep clears its request and runs waking interrupt.
// RQ8 - After wake routine returns, execution resumes after the sleep request.
// RQ9 - Both sleep bits together enter deep sleep; no light sleep after exit.
// RQ10 - Light sleep stops only processor clock and freezes program counter.
// RQ11 - Wake from light sleep clears request, runs interrupt, then resumes.
// RQ12 - Overflow sets flag; ISR entry clears it; software may write it.
// RQ13 - Run bit clear halts timer keeping count; set enables it.
// RQ14 - Edge mode: falling edge sets flag until software or ISR entry clears.
// RQ15 - Level mode: flag follows inverted pin level, software writes ignored.
// RQ16 - Trigger-type bit: 0 low-level, 1 falling-edge.
// RQ17 - With gate enabled, timer counts only while run is 1 and pin high.
// RQ18 - Pins synchronised before edge detection; edge sets flag in one cycle.
module power_timer_int_control_regs
	import pwr_tmr_ctl_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	input  wire logic                  por_in,
	input  wire logic [7:0]            sfr_addr_in,
	input  wire logic                  sfr_wr_in,
	input  wire logic [7:0]            sfr_wdata_in,
	input  wire logic                  sfr_rd_in,
	output logic      [7:0]            sfr_rdata_out,
	output logic                       sfr_rvalid_out,
	input  wire logic                  wake_in,
	input  wire logic                  timer_a_ovf_in,
	input  wire logic                  timer_b_ovf_in,
	input  wire logic                  timer_a_isr_in,
	input  wire logic                  timer_b_isr_in,
	input  wire logic                  ext_irq_a_isr_in,
	input  wire logic                  ext_irq_b_isr_in,
	input  wire logic                  ext_irq_a_pin_in,
	input  wire logic                  ext_irq_b_pin_in,
	input  wire logic                  timer_a_gate_in,
	input  wire logic                  timer_b_gate_in,
	input  wire logic [1:0]            serial_mode_in,
	input  wire logic                  timer_b_baud_src_in,
	output logic                       cpu_clk_en_out,
	output logic                       periph_clk_en_out,
	output logic                       pc_hold_out,
	output logic                       baud_double_out,
	output logic                       frame_err_view_sel_out,
	output logic                       timer_a_count_en_out,
	output logic                       timer_b_count_en_out,
	output power_control_type          power_control_out,
	output timer_int_control_type      timer_int_control_out
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic falling(input logic prev, input logic now);
		falling = prev & ~now;
	endfunction

	function automatic logic count_enable(input logic run,
			input logic gate, input logic pin);
		count_enable = run & (~gate | pin);
	endfunction

	function automatic logic addr_hit(input logic [7:0] addr,
			input logic [7:0] target);
		addr_hit = (addr == target);
	endfunction

	function automatic logic doubling_mode(input logic [1:0] mode,
			input logic timer_src);
		doubling_mode = (mode == SERIAL_MODE_2) ||
			(((mode == SERIAL_MODE_1) || (mode == SERIAL_MODE_3)) &&
			timer_src);
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	power_control_type     power_control;
	timer_int_control_type timer_int_control;
	power_control_type     wr_power_control;
	timer_int_control_type wr_timer_int_control;
	sleep_state_type       sleep_state;
	logic                  power_control_wr;
	logic                  timer_int_control_wr;
	logic                  pin_a_meta;
	logic                  pin_a_sync;
	logic                  pin_a_prev;
	logic                  pin_b_meta;
	logic                  pin_b_sync;
	logic                  pin_b_prev;
	logic                  edge_a;
	logic                  edge_b;
	logic                  waking;

	// ****************************************************************
	// Write decode and wake qualification
	// ****************************************************************
	assign wr_power_control = power_control_type'(sfr_wdata_in);
	assign wr_timer_int_control = timer_int_control_type'(sfr_wdata_in);
	assign power_control_wr = sfr_wr_in && addr_hit(sfr_addr_in, POWER_CONTROL_ADDR);
	assign timer_int_control_wr = sfr_wr_in && addr_hit(sfr_addr_in, TIMER_INT_CONTROL_ADDR);
	// Wake pulses while running are ignored
	assign waking  = wake_in && (sleep_state != ST_RUN);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			// Idle level after reset, so no false edge follows
			pin_a_meta <= PIN_IDLE_LEVEL;
			pin_a_sync <= PIN_IDLE_LEVEL;
			pin_a_prev <= PIN_IDLE_LEVEL;
			pin_b_meta <= PIN_IDLE_LEVEL;
			pin_b_sync <= PIN_IDLE_LEVEL;
			pin_b_prev <= PIN_IDLE_LEVEL;
		end else begin
			pin_a_meta <= ext_irq_a_pin_in; // RQ18
			pin_a_sync <= pin_a_meta;
			pin_a_prev <= pin_a_sync;
			pin_b_meta <= ext_irq_b_pin_in; // RQ18
			pin_b_sync <= pin_b_meta;
			pin_b_prev <= pin_b_sync;
		end
	end

	assign edge_a = falling(pin_a_prev, pin_a_sync); // RQ18
	assign edge_b = falling(pin_b_prev, pin_b_sync); // RQ18

	// ****************************************************************
	// Cold-start flag
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			// Warm resets leave the flag as it stands
			if (por_in) begin
				power_control.cold_start_flag <= COLD_START_SET; // RQ3
			end
		end else if (power_control_wr) begin
			power_control.cold_start_flag <= wr_power_control.cold_start_flag;
		end
	end

	// ****************************************************************
	// Power control storage
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			power_control.baud_double        <= POWER_CONTROL_RESET.baud_double;
			power_control.frame_err_view_sel <= POWER_CONTROL_RESET.frame_err_view_sel;
			power_control.reserved           <= POWER_CONTROL_RESET.reserved;
			power_control.general_flag_b     <= POWER_CONTROL_RESET.general_flag_b;
			power_control.general_flag_a     <= POWER_CONTROL_RESET.general_flag_a;
		end else if (power_control_wr) begin
			power_control.baud_double        <= wr_power_control.baud_double;
			power_control.frame_err_view_sel <= wr_power_control.frame_err_view_sel;
			power_control.general_flag_b     <= wr_power_control.general_flag_b; // RQ5
			power_control.general_flag_a     <= wr_power_control.general_flag_a; // RQ5
		end
	end

	// ****************************************************************
	// Sleep request bits
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			power_control.deep_sleep_req  <= POWER_CONTROL_RESET.deep_sleep_req;
			power_control.light_sleep_req <= POWER_CONTROL_RESET.light_sleep_req;
		end else if (waking) begin
			// Leaving deep sleep drops a pending light request too
			power_control.deep_sleep_req  <= 1'b0; // RQ7
			power_control.light_sleep_req <= 1'b0; // RQ9 RQ11
		end else if (power_control_wr) begin
			power_control.deep_sleep_req  <= wr_power_control.deep_sleep_req;
			power_control.light_sleep_req <= wr_power_control.light_sleep_req;
		end
	end

	// ****************************************************************
	// Sleep state machine
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sleep_state <= ST_RUN;
		end else begin
			// Request bit acts from the edge after its write
			case (sleep_state)
				ST_RUN: begin
					if (power_control.deep_sleep_req) begin
						sleep_state <= ST_DEEP_SLEEP; // RQ9
					end else if (power_control.light_sleep_req) begin
						sleep_state <= ST_LIGHT_SLEEP;
					end
				end
				ST_LIGHT_SLEEP: begin
					if (wake_in) begin
						sleep_state <= ST_RUN; // RQ11
					end
				end
				ST_DEEP_SLEEP: begin
					if (wake_in) begin
						sleep_state <= ST_RUN; // RQ7
					end
				end
				default: begin
					sleep_state <= ST_RUN;
				end
			endcase
		end
	end

	// Program counter is only held, never moved, so the core resumes
	// after the sleep request once the waking routine returns
	assign pc_hold_out       = (sleep_state != ST_RUN); // RQ6 RQ8 RQ10
	assign cpu_clk_en_out    = (sleep_state == ST_RUN); // RQ6 RQ10
	assign periph_clk_en_out = (sleep_state != ST_DEEP_SLEEP); // RQ6 RQ10

	// ****************************************************************
	// Timer run and overflow flags
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_int_control.timer_a_run <= TIMER_INT_CONTROL_RESET.timer_a_run;
			timer_int_control.timer_b_run <= TIMER_INT_CONTROL_RESET.timer_b_run;
		end else if (timer_int_control_wr) begin
			timer_int_control.timer_a_run <= wr_timer_int_control.timer_a_run; // RQ13
			timer_int_control.timer_b_run <= wr_timer_int_control.timer_b_run; // RQ13
		end
	end

	// Overflow outranks a same-cycle write or entry clear
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_int_control.timer_a_overflow <= TIMER_INT_CONTROL_RESET.timer_a_overflow;
		end else if (timer_a_ovf_in) begin
			timer_int_control.timer_a_overflow <= 1'b1; // RQ12
		end else if (timer_int_control_wr) begin
			timer_int_control.timer_a_overflow <= wr_timer_int_control.timer_a_overflow; // RQ12
		end else if (timer_a_isr_in) begin
			timer_int_control.timer_a_overflow <= 1'b0; // RQ12
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_int_control.timer_b_overflow <= TIMER_INT_CONTROL_RESET.timer_b_overflow;
		end else if (timer_b_ovf_in) begin
			timer_int_control.timer_b_overflow <= 1'b1; // RQ12
		end else if (timer_int_control_wr) begin
			timer_int_control.timer_b_overflow <= wr_timer_int_control.timer_b_overflow; // RQ12
		end else if (timer_b_isr_in) begin
			timer_int_control.timer_b_overflow <= 1'b0; // RQ12
		end
	end

	// Halted timer keeps its count bytes untouched outside this block
	assign timer_a_count_en_out = count_enable(timer_int_control.timer_a_run,
		timer_a_gate_in, pin_a_sync); // RQ13 RQ17
	assign timer_b_count_en_out = count_enable(timer_int_control.timer_b_run,
		timer_b_gate_in, pin_b_sync); // RQ13 RQ17

	// ****************************************************************
	// External interrupt type and flags
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_int_control.ext_irq_a_type <= TIMER_INT_CONTROL_RESET.ext_irq_a_type;
			timer_int_control.ext_irq_b_type <= TIMER_INT_CONTROL_RESET.ext_irq_b_type;
		end else if (timer_int_control_wr) begin
			timer_int_control.ext_irq_a_type <= wr_timer_int_control.ext_irq_a_type; // RQ16
			timer_int_control.ext_irq_b_type <= wr_timer_int_control.ext_irq_b_type; // RQ16
		end
	end

	// Level mode follows the pin; writes and entry clears are ignored
	// In edge mode a new edge outranks a same-cycle clear
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_int_control.ext_irq_a_flag <= TIMER_INT_CONTROL_RESET.ext_irq_a_flag;
		end else if (timer_int_control.ext_irq_a_type == TRIGGER_LOW_LEVEL) begin
			timer_int_control.ext_irq_a_flag <= ~pin_a_sync; // RQ15 RQ16
		end else if (edge_a) begin
			timer_int_control.ext_irq_a_flag <= 1'b1; // RQ14 RQ18
		end else if (timer_int_control_wr) begin
			timer_int_control.ext_irq_a_flag <= wr_timer_int_control.ext_irq_a_flag; // RQ14
		end else if (ext_irq_a_isr_in) begin
			timer_int_control.ext_irq_a_flag <= 1'b0; // RQ14
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_int_control.ext_irq_b_flag <= TIMER_INT_CONTROL_RESET.ext_irq_b_flag;
		end else if (timer_int_control.ext_irq_b_type == TRIGGER_LOW_LEVEL) begin
			timer_int_control.ext_irq_b_flag <= ~pin_b_sync; // RQ15 RQ16
		end else if (edge_b) begin
			timer_int_control.ext_irq_b_flag <= 1'b1; // RQ14 RQ18
		end else if (timer_int_control_wr) begin
			timer_int_control.ext_irq_b_flag <= wr_timer_int_control.ext_irq_b_flag; // RQ14
		end else if (ext_irq_b_isr_in) begin
			timer_int_control.ext_irq_b_flag <= 1'b0; // RQ14
		end
	end

	// ****************************************************************
	// Serial port controls
	// ****************************************************************
	assign baud_double_out = power_control.baud_double &&
		doubling_mode(serial_mode_in, timer_b_baud_src_in); // RQ1
	assign frame_err_view_sel_out = power_control.frame_err_view_sel; // RQ2

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sfr_rdata_out  <= READ_UNMAPPED;
			sfr_rvalid_out <= 1'b0;
		end else begin
			// A same-cycle write shows only on a later read
			sfr_rvalid_out <= sfr_rd_in;
			if (!sfr_rd_in) begin
				sfr_rdata_out <= READ_UNMAPPED;
			end else if (addr_hit(sfr_addr_in, POWER_CONTROL_ADDR)) begin
				sfr_rdata_out <= 8'(power_control);
			end else if (addr_hit(sfr_addr_in, TIMER_INT_CONTROL_ADDR)) begin
				sfr_rdata_out <= 8'(timer_int_control);
			end else begin
				sfr_rdata_out <= READ_UNMAPPED;
			end
		end
	end

	// ****************************************************************
	// Register views
	// ****************************************************************
	assign power_control_out     = power_control;
	assign timer_int_control_out = timer_int_control;

endmodule

// ### bench/pwr_tmr_ctl_sva.sv
`timescale 1ns/1ps
module pwr_tmr_ctl_sva
	import pwr_tmr_ctl_pkg::*;
(
	input wire logic                  clk_in,
	input wire logic                  srst_in,
	input wire logic                  por_in,
	input wire logic [7:0]            sfr_addr_in,
	input wire logic                  sfr_wr_in,
	input wire logic [7:0]            sfr_wdata_in,
	input wire logic                  wake_in,
	input wire logic                  timer_a_ovf_in,
	input wire logic                  ext_irq_a_pin_in,
	input wire logic [1:0]            serial_mode_in,
	input wire logic                  timer_b_baud_src_in,
	input wire logic                  cpu_clk_en_out,
	input wire logic                  periph_clk_en_out,
	input wire logic                  pc_hold_out,
	input wire logic                  baud_double_out,
	input wire logic                  frame_err_view_sel_out,
	input wire power_control_type     power_control_out,
	input wire timer_int_control_type timer_int_control_out
);
	// ****
	// Checks
	// ****
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);

	cold_keep_a: assert property (@(posedge clk_in) disable iff (1'b0)
		srst_in |=> power_control_out.cold_start_flag ==
		($past(por_in) || $past(power_control_out.cold_start_flag)))
		else $error("cold start flag wrong after reset");
	view_sel_a: assert property (sfr_wr_in &&
		sfr_addr_in == POWER_CONTROL_ADDR
		|=> frame_err_view_sel_out == $past(sfr_wdata_in[6]))
		else $error("view select does not follow write");
	baud_dbl_a: assert property (baud_double_out ==
		(power_control_out.baud_double &&
		(serial_mode_in == SERIAL_MODE_2 || (timer_b_baud_src_in &&
		(serial_mode_in == SERIAL_MODE_1 ||
		serial_mode_in == SERIAL_MODE_3)))))
		else $error("baud doubling wrong");
	deep_stop_a: assert property (power_control_out.deep_sleep_req &&
		!wake_in |=> !cpu_clk_en_out && !periph_clk_en_out && pc_hold_out)
		else $error("deep sleep left a clock running");
	light_stop_a: assert property (power_control_out.light_sleep_req &&
		!power_control_out.deep_sleep_req && !wake_in
		|=> !cpu_clk_en_out && periph_clk_en_out && pc_hold_out)
		else $error("light sleep clocks wrong");
	wake_clear_a: assert property (wake_in && pc_hold_out |=>
		!power_control_out.deep_sleep_req &&
		!power_control_out.light_sleep_req &&
		cpu_clk_en_out && periph_clk_en_out)
		else $error("wake did not restore run");
	ovf_set_a: assert property (timer_a_ovf_in |=>
		timer_int_control_out.timer_a_overflow)
		else $error("overflow flag not set");
	edge_flag_a: assert property (timer_int_control_out.ext_irq_a_type &&
		$fell(ext_irq_a_pin_in) |-> ##3 timer_int_control_out.ext_irq_a_flag)
		else $error("edge flag not set in time");
	level_flag_a: assert property (
		!timer_int_control_out.ext_irq_a_type[*2]
		|-> timer_int_control_out.ext_irq_a_flag == !$past(ext_irq_a_pin_in, 3))
		else $error("level flag does not track pin");

	deep_c: cover property (power_control_out.deep_sleep_req && pc_hold_out);
	wake_c: cover property (wake_in && pc_hold_out);
	edge_c: cover property (timer_int_control_out.ext_irq_a_type &&
		$fell(ext_irq_a_pin_in));
endmodule

bind power_timer_int_control_regs pwr_tmr_ctl_sva i_sva (.clk_in, .srst_in,
	.por_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .wake_in,
	.timer_a_ovf_in, .ext_irq_a_pin_in, .serial_mode_in,
	.timer_b_baud_src_in, .cpu_clk_en_out, .periph_clk_en_out, .pc_hold_out,
	.baud_double_out, .frame_err_view_sel_out, .power_control_out,
	.timer_int_control_out);

// ### bench/core_model.sv
`timescale 1ns/1ps
module core_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output logic      [7:0] addr_out,
	output logic            wr_out,
	output logic      [7:0] wdata_out,
	output logic            rd_out
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(posedge clk_in);
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule

// ### bench/power_timer_int_control_regs_tb.sv
`timescale 1ns/1ps
module power_timer_int_control_regs_tb
	import pwr_tmr_ctl_pkg::*;
;
	logic clk_in, srst_in, por_in, wake_in, sfr_wr_in, sfr_rd_in, v;
	logic timer_a_ovf_in, timer_b_ovf_in, timer_a_isr_in, timer_b_isr_in;
	logic ext_irq_a_isr_in, ext_irq_b_isr_in, ext_irq_a_pin_in;
	logic ext_irq_b_pin_in, timer_a_gate_in, timer_b_gate_in;
	logic timer_b_baud_src_in, sfr_rvalid_out, cpu_clk_en_out;
	logic periph_clk_en_out, pc_hold_out, baud_double_out;
	logic frame_err_view_sel_out, timer_a_count_en_out, timer_b_count_en_out;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, r;
	logic [1:0] serial_mode_in;
	power_control_type     power_control_out;
	timer_int_control_type timer_int_control_out;
	int fails, n_checks, seed, m_pc;
	int slp[3] = '{3, 2, 1};

	core_model i_core (.clk_in, .rdata_in(sfr_rdata_out),
		.rvalid_in(sfr_rvalid_out), .addr_out(sfr_addr_in),
		.wr_out(sfr_wr_in), .wdata_out(sfr_wdata_in), .rd_out(sfr_rd_in));
	power_timer_int_control_regs i_dut (.clk_in, .srst_in, .por_in,
		.sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rd_in, .sfr_rdata_out,
		.sfr_rvalid_out, .wake_in, .timer_a_ovf_in, .timer_b_ovf_in,
		.timer_a_isr_in, .timer_b_isr_in, .ext_irq_a_isr_in,
		.ext_irq_b_isr_in, .ext_irq_a_pin_in, .ext_irq_b_pin_in,
		.timer_a_gate_in, .timer_b_gate_in, .serial_mode_in,
		.timer_b_baud_src_in, .cpu_clk_en_out, .periph_clk_en_out,
		.pc_hold_out, .baud_double_out, .frame_err_view_sel_out,
		.timer_a_count_en_out, .timer_b_count_en_out, .power_control_out,
		.timer_int_control_out);

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// ****
	// Helpers
	// ****
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({7'h00, got}, {7'h00, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		i_core.rd(a, r, v);
		chk_bit(v, 1'b1);
		chk_reg(r, exp);
	endtask
	task automatic rst(input logic p);
		srst_in <= 1'b1;
		por_in <= p;
		tick(2);
		srst_in <= 1'b0;
		por_in <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		tick(3000);
		fails++;
		give_verdict();
	end

	// ****
	// Tests
	// ****
	initial begin
		seed = 32'h992774FC;
		fails = 0;
		n_checks = 0;
		{srst_in, por_in, ext_irq_a_pin_in, ext_irq_b_pin_in} = 4'hF;
		{wake_in, timer_a_ovf_in, timer_b_ovf_in, timer_a_isr_in} = 4'h0;
		{timer_b_isr_in, ext_irq_a_isr_in, ext_irq_b_isr_in} = 3'h0;
		{timer_a_gate_in, timer_b_gate_in, timer_b_baud_src_in} = 3'h0;
		serial_mode_in = 2'h0;
		tick(4);
		srst_in <= 1'b0;
		por_in <= 1'b0;
		rd_chk(POWER_CONTROL_ADDR, 8'h10);
		rd_chk(TIMER_INT_CONTROL_ADDR, 8'h00);
		i_core.wr(POWER_CONTROL_ADDR, 8'h00);
		for (int k = 1; k >= 0; k--) begin
			i_core.wr(POWER_CONTROL_ADDR, 8'(k << 4));
			rst(1'b0);
			rd_chk(POWER_CONTROL_ADDR, 8'(k << 4));
		end
		repeat (6) begin
			m_pc = $random(seed) & 'hFC;
			i_core.wr(POWER_CONTROL_ADDR, 8'(m_pc));
			m_pc = m_pc & 'hDF;
			rd_chk(POWER_CONTROL_ADDR, 8'(m_pc));
			chk_bit(frame_err_view_sel_out, m_pc[6]);
			for (int k = 0; k < 8; k++) begin
				serial_mode_in <= 2'(k);
				timer_b_baud_src_in <= k[2];
				tick(1);
				chk_bit(baud_double_out, m_pc[7] &&
					(k[1:0] == 2 || (k[0] && k[2])));
			end
		end
		i_core.wr(8'h86, 8'hFF);
		rd_chk(8'h86, READ_UNMAPPED);
		rd_chk(POWER_CONTROL_ADDR, 8'(m_pc));
		foreach (slp[i]) begin
			i_core.wr(POWER_CONTROL_ADDR, 8'(m_pc | slp[i]));
			tick(2);
			chk_bit(cpu_clk_en_out, 1'b0);
			chk_bit(periph_clk_en_out, !slp[i][1]);
			chk_bit(pc_hold_out, 1'b1);
			wake_in <= 1'b1;
			tick(1);
			wake_in <= 1'b0;
			tick(1);
			chk_reg(power_control_out, 8'(m_pc));
			chk_bit(cpu_clk_en_out && periph_clk_en_out, 1'b1);
		end
		i_core.wr(TIMER_INT_CONTROL_ADDR, 8'h50);
		{timer_a_gate_in, timer_b_gate_in, ext_irq_a_pin_in} <= 3'b110;
		tick(4);
		chk_bit(timer_a_count_en_out, 1'b0);
		chk_bit(timer_b_count_en_out, 1'b1);
		i_core.wr(TIMER_INT_CONTROL_ADDR, 8'h58);
		rd_chk(TIMER_INT_CONTROL_ADDR, 8'h52);
		{timer_a_gate_in, ext_irq_a_pin_in} <= 2'b11;
		tick(4);
		chk_bit(timer_a_count_en_out, 1'b1);
		chk_reg(timer_int_control_out, 8'h50);
		i_core.wr(TIMER_INT_CONTROL_ADDR, 8'h40);
		tick(1);
		chk_bit(timer_a_count_en_out, 1'b0);
		{timer_a_ovf_in, timer_b_ovf_in} <= 2'b11;
		tick(1);
		{timer_a_ovf_in, timer_b_ovf_in} <= 2'b00;
		tick(1);
		chk_reg(timer_int_control_out, 8'hE0);
		{timer_a_isr_in, timer_b_isr_in} <= 2'b11;
		tick(1);
		{timer_a_isr_in, timer_b_isr_in} <= 2'b00;
		tick(1);
		chk_reg(timer_int_control_out, 8'h40);
		i_core.wr(TIMER_INT_CONTROL_ADDR, 8'hA0);
		rd_chk(TIMER_INT_CONTROL_ADDR, 8'hA0);
		i_core.wr(TIMER_INT_CONTROL_ADDR, 8'h05);
		{ext_irq_a_pin_in, ext_irq_b_pin_in} <= 2'b00;
		tick(3);
		chk_reg(timer_int_control_out, 8'h05);
		tick(1);
		chk_reg(timer_int_control_out, 8'h0F);
		{ext_irq_a_pin_in, ext_irq_b_pin_in} <= 2'b11;
		tick(4);
		chk_reg(timer_int_control_out, 8'h0F);
		ext_irq_a_isr_in <= 1'b1;
		tick(1);
		ext_irq_a_isr_in <= 1'b0;
		tick(1);
		chk_reg(timer_int_control_out, 8'h0D);
		i_core.wr(TIMER_INT_CONTROL_ADDR, 8'h05);
		rd_chk(TIMER_INT_CONTROL_ADDR, 8'h05);
		give_verdict();
	end
endmodule
